// >>> adc_test_pattern_serial_link_ctrl_tb.sv
// Purpose: Register-level tests of the lane configuration bank
// Assumes: ce_i held high; rdata_o valid only in the cycle after rd
// Notes: Soft reset outputs stand for RST_CYCLES cycles
`timescale 1ns/100ps
module adc_test_pattern_serial_link_ctrl_tb;
   import lane_cfg_pkg::*;
   localparam logic [7:0] ID = 8'h5a; // Arbitrary identity value
   localparam int RST = 4;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic sample_valid_i = 1'b0;
   logic [15:0] sample_i = 16'h0000;
   reg_req_t req = '0;
   logic want = 1'b0;
   logic err = 1'b0;
   logic sync_req, sync_error, sync_asserted_o, unit_rst_o, fsm_rst_o, irq_o;
   logic [7:0] rdata_o, link_id_o;
   logic [15:0] sample_o, s, s2, n;
   logic [2:0] pad_swing_o;
   link_cfg_t link_cfg_o;
   logic [7:0] trim [4] = '{8'h1f, 8'h20, 8'h00, 8'h3f};
   logic [15:0] pat [8] = '{16'h0, 16'h8000, 16'h0000, 16'hffff, 16'h0, 16'h1234, 16'h5555, 16'haaaa};
   int failures = 0;
   int n_compared = 0;
   // ***********************
   // Clock, parts and tasks
   // ***********************
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   lane_cfg_bank #(.LINK_ID(ID), .RST_CYCLES(RST)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .req_i(req), .rdata_o(rdata_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .sample_o(sample_o), .sync_req_i(sync_req), .sync_error_i(sync_error), .sync_asserted_o(sync_asserted_o),
      .unit_rst_o(unit_rst_o), .fsm_rst_o(fsm_rst_o), .link_cfg_o(link_cfg_o), .link_id_o(link_id_o),
      .pad_swing_o(pad_swing_o), .irq_o(irq_o));
   rx_sync_model u_rx (.clk_i(clk_i), .act_high_i(link_cfg_o.sync_active_high), .want_i(want), .err_i(err),
      .sync_req_o(sync_req), .sync_error_o(sync_error));
   task automatic chk(input logic [15:0] sv, input logic [15:0] ev);
      n_compared++;
      if (sv !== ev) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ev);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      req <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_i);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      req <= '0;
      #1 chk(rdata_o, e);
   endtask
   task automatic smp(input logic [15:0] v, output logic [15:0] o);
      @(posedge clk_i);
      sample_i <= v;
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      #1 o = sample_o;
   endtask
   task automatic pulse;
      @(posedge clk_i);
      err <= 1'b1;
      @(posedge clk_i);
      err <= 1'b0;
   endtask
   task automatic end_sim;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog well beyond the under two hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_i);
      failures++;
      end_sim();
   end
   // Test sequence
   initial begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(12'h015, 8'h00);
      rd(12'h016, 8'h00);
      rd(12'h801, 8'h60);
      rd(12'h809, 8'h00);
      rd(12'h80a, 8'hff);
      rd(12'h80b, 8'h00);
      rd(12'h808, 8'h03);
      wr(12'h820, 8'h00);
      rd(12'h820, ID);
      rd(12'h123, 8'h00);
      chk(link_id_o, ID);
      $display("test reset_values done");
      wr(12'h015, 8'h12);
      wr(12'h016, 8'h34);
      wr(12'h809, 8'h55);
      wr(12'h80a, 8'h3c);
      wr(12'h805, 8'h07);
      wr(12'h871, 8'h40);
      rd(12'h015, 8'h12);
      rd(12'h016, 8'h34);
      rd(12'h805, 8'h0f);
      chk(link_cfg_o.scr_seed, {8'h3c, 7'h55});
      chk(link_cfg_o.prbs_source, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(12'h80b, i[7:0]);
         #1 chk(link_cfg_o.sequence_type_select, i[1:0]);
      end
      $display("test registers done");
      wr(12'h014, 8'h00);
      foreach (trim[k]) begin
         wr(12'h013, trim[k]);
         smp(16'h0010, s);
         chk(s, 16'h0010 + {{10{trim[k][5]}}, trim[k][5:0]});
      end
      for (int i = 1; i < 8; i++) begin
         wr(12'h014, i[7:0]);
         smp(16'h0100, s);
         smp(16'h0100, s2);
         if (i == 4)
            chk({s ^ s2, s ^ {16{s[0]}}}, {16'hffff, 16'h0});
         else
            chk(s, pat[i]);
      end
      $display("test sample_path done");
      for (int p = 0; p < 2; p++) begin
         wr(12'h805, {2'b00, p[0], 5'h00});
         for (int w = 0; w < 2; w++) begin
            @(posedge clk_i);
            want <= w[0];
            repeat (2) @(posedge clk_i);
            #1 chk(sync_asserted_o, w[0]);
         end
      end
      $display("test sync_polarity done");
      wr(12'h901, 8'h80);
      pulse();
      rd(12'h801, 8'he0);
      rd(12'h801, 8'he0);
      chk(irq_o, 1'b1);
      rd(12'h900, 8'h80);
      wr(12'h801, 8'h00);
      rd(12'h801, 8'h60);
      chk(irq_o, 1'b0);
      pulse();
      wr(12'h901, 8'h00);
      rd(12'h900, 8'h80);
      chk(irq_o, 1'b0);
      wr(12'h902, 8'h80);
      rd(12'h900, 8'h00);
      $display("test sync_fault done");
      wr(12'h802, 8'h80);
      #1 n = unit_rst_o;
      repeat (8) begin
         @(posedge clk_i);
         #1 n += unit_rst_o;
      end
      chk(n, RST);
      wr(12'h802, 8'h08);
      #1 chk({fsm_rst_o, unit_rst_o}, 2'b10);
      repeat (8) @(posedge clk_i);
      $display("test soft_reset done");
      end_sim();
   end
endmodule
bind lane_cfg_bank lane_cfg_props #(.LINK_ID(LINK_ID)) u_props (.*);

// >>> lane_cfg_bank.sv
// Purpose: Register bank for offset trim, test pattern and serial lane controls
// Assumes: Single clock, synchronous inputs, plain register port
// Notes: Data path applies trim then pattern; lane cfg is exported as a struct
// Behaviour
// R1 - A six-bit signed offset from +31 to -32 LSB is added to the sample, zero meaning none.
// R2 - A three-bit selector replaces the sample with off, mid, -FS, +FS, toggle, custom or alternating patterns.
// R3 - Custom word bits 15..8 come from their own RW register that resets to zero.
// R4 - Custom word bits 7..0 come from their own RW register that resets to zero.
// R5 - Status bit 7 is set on a link sync error and resets to zero.
// R6 - Writing one to reset bit 7 resets the whole serial unit.
// R7 - Writing one to reset bit 3 resets only the serial state machine.
// R8 - Control bit 5 picks sync polarity, 0 active low and 1 active high.
// R9 - Control bit 2 reverses word bit order into the scrambler.
// R10 - Control bit 1 reverses byte bit order into the encoder.
// R11 - Control bit 0 reverses code word bit order into the lane.
// R12 - Scrambler seed bits 6..0 come from an RW field reset to zero.
// R13 - Scrambler seed bits 14..7 come from an RW field reset to all ones.
// R14 - A two-bit field picks PRBS-7 for 00 and 01, PRBS-23 for 10, PRBS-31 for 11.
// R15 - An eight-bit read-only link identifier is readable and drives the link identity.
// R16 - When the source bit is one the scrambler and encoder take PRBS data instead of frames.
// R17 - The sync fault flag stays set until software writes zero to it; the code also clears it on a write of one to interrupt clear bit 7.
`timescale 1ns/100ps
`include "lane_cfg_defines.svh"
module lane_cfg_bank #(
   parameter logic [7:0] LINK_ID = 8'h3c, // Arbitrary identity value
   parameter int SAMPLE_W = 16,
   parameter int RST_CYCLES = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire lane_cfg_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   output logic [SAMPLE_W-1:0] sample_o,
   input wire logic sync_req_i,
   input wire logic sync_error_i,
   output logic sync_asserted_o,
   output logic unit_rst_o,
   output logic fsm_rst_o,
   output lane_cfg_pkg::link_cfg_t link_cfg_o,
   output logic [7:0] link_id_o,
   output logic [2:0] pad_swing_o,
   output logic irq_o
);
   import lane_cfg_pkg::*;

   // ***************************
   // Elaboration checks
   // ***************************
   if (SAMPLE_W != 16) begin : g_bad_w
      $error("lane_cfg_bank supports only 16-bit samples");
   end
   if (RST_CYCLES < 1 || RST_CYCLES > 255) begin : g_bad_rst
      $error("RST_CYCLES must be 1 to 255");
   end

   // ***************************
   // Register state
   // ***************************
   logic [5:0] trim_q, trim_d;
   pattern_t pat_q, pat_d;
   logic [7:0] cust_hi_q, cust_hi_d, cust_lo_q, cust_lo_d;
   logic fault_q, fault_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [2:0] swing_q, swing_d;
   logic [6:0] seed_lo_q, seed_lo_d;
   logic [7:0] seed_hi_q, seed_hi_d;
   prbs_t prbs_q, prbs_d;
   logic src_q, src_d;
   logic irq_en_q, irq_en_d;
   logic [7:0] rdata_q, rdata_d;
   link_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic unit_q, unit_d, fsm_q, fsm_d;
   logic [SAMPLE_W-1:0] out_q, out_d;
   logic toggle_q, toggle_d;

   // Exact address match shared by write and read paths
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // ***************************
   // Register writes and reads
   // ***************************
   // Set wins over a clear in the same cycle so a fault is never lost
   always_comb begin
      trim_d = trim_q;
      pat_d = pat_q;
      cust_hi_d = cust_hi_q;
      cust_lo_d = cust_lo_q;
      ctrl_d = ctrl_q;
      swing_d = swing_q;
      seed_lo_d = seed_lo_q;
      seed_hi_d = seed_hi_q;
      prbs_d = prbs_q;
      src_d = src_q;
      irq_en_d = irq_en_q;
      fault_d = fault_q;
      rdata_d = `ZERO8;
      if (req_i.wr) begin
         if (hit(req_i.addr, `OFS_OFFSET_TRIM)) begin
            trim_d = req_i.wdata[5:0];
         end else if (hit(req_i.addr, `OFS_PATTERN_SEL)) begin
            pat_d = pattern_t'(req_i.wdata[2:0]);
         end else if (hit(req_i.addr, `OFS_CUSTOM_HIGH)) begin
            cust_hi_d = req_i.wdata; // [R3]
         end else if (hit(req_i.addr, `OFS_CUSTOM_LOW)) begin
            cust_lo_d = req_i.wdata; // [R4]
         end else if (hit(req_i.addr, `OFS_LINK_STATUS)) begin
            if (!req_i.wdata[`BIT_SYNC_FAULT]) begin
               fault_d = 1'b0; // [R17]
            end
         end else if (hit(req_i.addr, `OFS_LINK_CTRL)) begin
            ctrl_d = req_i.wdata;
         end else if (hit(req_i.addr, `OFS_PAD_SWING)) begin
            swing_d = req_i.wdata[2:0];
         end else if (hit(req_i.addr, `OFS_SEED_LOW)) begin
            seed_lo_d = req_i.wdata[6:0]; // [R12]
         end else if (hit(req_i.addr, `OFS_SEED_HIGH)) begin
            seed_hi_d = req_i.wdata; // [R13]
         end else if (hit(req_i.addr, `OFS_PRBS_SEL)) begin
            prbs_d = prbs_t'(req_i.wdata[1:0]);
         end else if (hit(req_i.addr, `OFS_LANE_CTRL)) begin
            src_d = req_i.wdata[`BIT_SCR_SRC];
         end else if (hit(req_i.addr, `OFS_IRQ_ENABLE)) begin
            irq_en_d = req_i.wdata[`BIT_SYNC_FAULT];
         end else if (hit(req_i.addr, `OFS_IRQ_CLEAR)) begin
            if (req_i.wdata[`BIT_SYNC_FAULT]) begin
               fault_d = 1'b0;
            end
         end
      end
      if (sync_error_i) begin
         fault_d = 1'b1; // [R5]
      end
      if (req_i.rd) begin
         if (hit(req_i.addr, `OFS_OFFSET_TRIM)) begin
            rdata_d = {2'b00, trim_q};
         end else if (hit(req_i.addr, `OFS_PATTERN_SEL)) begin
            rdata_d = {5'h00, pat_q};
         end else if (hit(req_i.addr, `OFS_CUSTOM_HIGH)) begin
            rdata_d = cust_hi_q;
         end else if (hit(req_i.addr, `OFS_CUSTOM_LOW)) begin
            rdata_d = cust_lo_q;
         end else if (hit(req_i.addr, `OFS_LINK_STATUS)) begin
            rdata_d = `STATUS_RSVD | {fault_q, 7'h00};
         end else if (hit(req_i.addr, `OFS_IRQ_STATUS)) begin
            // Interrupt status shares the enable layout, so no reserved bits show here
            rdata_d = {fault_q, 7'h00}; // [R5]
         end else if (hit(req_i.addr, `OFS_LINK_RESET)) begin
            rdata_d = {unit_q, 3'h0, fsm_q, 3'h0};
         end else if (hit(req_i.addr, `OFS_LINK_CTRL)) begin
            rdata_d = {2'b00, ctrl_q[5:4], 1'b1, ctrl_q[2:0]};
         end else if (hit(req_i.addr, `OFS_PAD_SWING)) begin
            rdata_d = {5'h00, swing_q};
         end else if (hit(req_i.addr, `OFS_SEED_LOW)) begin
            rdata_d = {1'b0, seed_lo_q};
         end else if (hit(req_i.addr, `OFS_SEED_HIGH)) begin
            rdata_d = seed_hi_q;
         end else if (hit(req_i.addr, `OFS_PRBS_SEL)) begin
            rdata_d = {6'h00, prbs_q};
         end else if (hit(req_i.addr, `OFS_LINK_ID)) begin
            rdata_d = LINK_ID; // [R15]
         end else if (hit(req_i.addr, `OFS_LANE_CTRL)) begin
            rdata_d = {1'b0, src_q, 6'h00};
         end else if (hit(req_i.addr, `OFS_IRQ_ENABLE)) begin
            rdata_d = {irq_en_q, 7'h00};
         end
      end
   end

   // ***************************
   // Serial unit soft reset sequencer
   // ***************************
   // Reset bits self-clear after a fixed hold so software need not write zero
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unit_d = unit_q;
      fsm_d = fsm_q;
      case (st_q)
         LINK_RUN: begin
            if (req_i.wr && hit(req_i.addr, `OFS_LINK_RESET) &&
                (req_i.wdata[`BIT_UNIT_RST] || req_i.wdata[`BIT_FSM_RST])) begin
               unit_d = req_i.wdata[`BIT_UNIT_RST]; // [R6]
               fsm_d = req_i.wdata[`BIT_FSM_RST] | req_i.wdata[`BIT_UNIT_RST]; // [R7]
               cnt_d = 8'(RST_CYCLES - 1);
               st_d = LINK_RESET;
            end
         end
         LINK_RESET: begin
            if (cnt_q == 8'h00) begin
               unit_d = 1'b0;
               fsm_d = 1'b0;
               st_d = LINK_RUN;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: st_d = LINK_RUN;
      endcase
   end

   // ***************************
   // Sample path
   // ***************************
   // Trim applied before pattern so test words stay exact
   always_comb begin
      logic [SAMPLE_W-1:0] trimmed;
      trimmed = sample_i + {{(SAMPLE_W-6){trim_q[5]}}, trim_q}; // [R1]
      toggle_d = toggle_q;
      out_d = out_q;
      if (sample_valid_i) begin
         toggle_d = ~toggle_q;
         case (pat_q) // [R2]
            PAT_OFF: out_d = trimmed;
            PAT_MID: out_d = `MID_SCALE;
            PAT_NEG: out_d = `NEG_FS;
            PAT_POS: out_d = `POS_FS;
            PAT_TOGGLE: out_d = toggle_q ? `POS_FS : `NEG_FS;
            PAT_CUSTOM: out_d = {cust_hi_q, cust_lo_q}; // [R3] [R4]
            PAT_ALT_A: out_d = `ALT_A;
            PAT_ALT_B: out_d = `ALT_B;
            default: out_d = trimmed;
         endcase
      end
   end

   // ***************************
   // Registers
   // ***************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         trim_q <= 6'h00;
         pat_q <= PAT_OFF;
         cust_hi_q <= 8'h00;
         cust_lo_q <= 8'h00;
         fault_q <= 1'b0;
         ctrl_q <= `CTRL_FIXED;
         swing_q <= `RST_SWING;
         seed_lo_q <= `RST_SEED_LOW;
         seed_hi_q <= `RST_SEED_HIGH;
         prbs_q <= PRBS_7A;
         src_q <= 1'b0;
         irq_en_q <= 1'b0;
         rdata_q <= 8'h00;
         st_q <= LINK_RUN;
         cnt_q <= 8'h00;
         unit_q <= 1'b0;
         fsm_q <= 1'b0;
         out_q <= '0;
         toggle_q <= 1'b0;
      end else if (ce_i) begin
         trim_q <= trim_d;
         pat_q <= pat_d;
         cust_hi_q <= cust_hi_d;
         cust_lo_q <= cust_lo_d;
         fault_q <= fault_d;
         ctrl_q <= ctrl_d;
         swing_q <= swing_d;
         seed_lo_q <= seed_lo_d;
         seed_hi_q <= seed_hi_d;
         prbs_q <= prbs_d;
         src_q <= src_d;
         irq_en_q <= irq_en_d;
         rdata_q <= rdata_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         unit_q <= unit_d;
         fsm_q <= fsm_d;
         out_q <= out_d;
         toggle_q <= toggle_d;
      end
   end

   // ***************************
   // Outputs
   // ***************************
   assign rdata_o = rdata_q;
   assign sample_o = out_q;
   assign unit_rst_o = unit_q;
   assign fsm_rst_o = fsm_q;
   assign pad_swing_o = swing_q;
   assign link_id_o = LINK_ID; // [R15]
   assign irq_o = fault_q & irq_en_q;
   // Polarity normalised here so downstream logic sees active high
   assign sync_asserted_o = ctrl_q[`BIT_SYNC_POLARITY_SELECT] ? sync_req_i : ~sync_req_i; // [R8]
   assign link_cfg_o.sync_active_high = ctrl_q[`BIT_SYNC_POLARITY_SELECT];
   assign link_cfg_o.rev_scrambler = ctrl_q[`BIT_SCRAMBLER_INPUT_BIT_REVERSE]; // [R9]
   assign link_cfg_o.rev_encoder = ctrl_q[`BIT_REV_ENC]; // [R10]
   assign link_cfg_o.rev_serial = ctrl_q[`BIT_REV_SER]; // [R11]
   assign link_cfg_o.prbs_source = src_q; // [R16]
   assign link_cfg_o.sequence_type_select = prbs_q; // [R14]
   assign link_cfg_o.scr_seed = {seed_hi_q, seed_lo_q}; // [R12] [R13]
endmodule

// >>> lane_cfg_defines.svh
// Purpose: Offsets, field positions, reset values for the lane configuration bank
// Assumes: Register index equals printed offset (offsets not all multiples of four)
// Notes: Definitions only
`ifndef LANE_CFG_DEFINES_SVH
`define LANE_CFG_DEFINES_SVH
`define ADDR_W 12
`define OFS_OFFSET_TRIM 12'h013
`define OFS_PATTERN_SEL 12'h014
`define OFS_CUSTOM_HIGH 12'h015
`define OFS_CUSTOM_LOW 12'h016
`define OFS_LINK_STATUS 12'h801
`define OFS_LINK_RESET 12'h802
`define OFS_LINK_CTRL 12'h805
`define OFS_PAD_SWING 12'h808
`define OFS_SEED_LOW 12'h809
`define OFS_SEED_HIGH 12'h80a
`define OFS_PRBS_SEL 12'h80b
`define OFS_LINK_ID 12'h820
`define OFS_LANE_CTRL 12'h871
`define OFS_IRQ_STATUS 12'h900
`define OFS_IRQ_ENABLE 12'h901
`define OFS_IRQ_CLEAR 12'h902
`define BIT_SYNC_FAULT 7
`define BIT_UNIT_RST 7
`define BIT_FSM_RST 3
`define BIT_SYNC_POLARITY_SELECT 5
`define BIT_SCRAMBLER_INPUT_BIT_REVERSE 2
`define BIT_REV_ENC 1
`define BIT_REV_SER 0
`define BIT_SCR_SRC 6
`define STATUS_RSVD 8'h60
`define CTRL_FIXED 8'h08
`define RST_SWING 3'h3
`define RST_SEED_LOW 7'h00
`define RST_SEED_HIGH 8'hff
`define MID_SCALE 16'h8000
`define NEG_FS 16'h0000
`define POS_FS 16'hffff
`define ALT_A 16'h5555
`define ALT_B 16'haaaa
`define ZERO8 8'h00
`endif

// >>> lane_cfg_pkg.sv
// Purpose: Types for the lane configuration bank
// Assumes: Nothing
// Notes: Constants live in the defines header
package lane_cfg_pkg;
   typedef enum logic [2:0] {
      PAT_OFF, PAT_MID, PAT_NEG, PAT_POS, PAT_TOGGLE, PAT_CUSTOM, PAT_ALT_A, PAT_ALT_B
   } pattern_t;
   typedef enum logic [1:0] {PRBS_7A, PRBS_7B, PRBS_23, PRBS_31} prbs_t;
   typedef enum {LINK_RUN, LINK_RESET} link_state_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic sync_active_high;
      logic rev_scrambler;
      logic rev_encoder;
      logic rev_serial;
      logic prbs_source;
      prbs_t sequence_type_select;
      logic [14:0] scr_seed;
   } link_cfg_t;
endpackage

// >>> lane_cfg_properties.sv
// Purpose: Port-level checks of the lane configuration bank
// Assumes: ce_i held high by the bench, default RST_CYCLES of 4
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module lane_cfg_props #(
   parameter logic [7:0] LINK_ID = 8'h3c
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire lane_cfg_pkg::reg_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic sync_req_i,
   input wire logic sync_error_i,
   input wire logic sync_asserted_o,
   input wire logic unit_rst_o,
   input wire logic fsm_rst_o,
   input wire lane_cfg_pkg::link_cfg_t link_cfg_o,
   input wire logic [7:0] link_id_o,
   input wire logic irq_o
);
   import lane_cfg_pkg::*;
   // ***********************
   // Helpers and properties
   // ***********************
   logic go;
   logic rs;
   // Writes only count outside a soft reset; during one the bank ignores only writes to the reset register
   assign go = ce_i && req_i.wr && !unit_rst_o && !fsm_rst_o;
   assign rs = ce_i && req_i.rd && req_i.addr == 12'h801;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_pol;
      sync_asserted_o == (link_cfg_o.sync_active_high ? sync_req_i : !sync_req_i);
   endproperty
   a_pol: assert property (p_pol) else $error("sync sense wrong");
   property p_id;
      link_id_o == LINK_ID;
   endproperty
   a_id: assert property (p_id) else $error("link id wrong");
   property p_unit;
      go && req_i.addr == 12'h802 && req_i.wdata[7] |=> (unit_rst_o && fsm_rst_o) [*4] ##1 !unit_rst_o;
   endproperty
   a_unit: assert property (p_unit) else $error("unit reset length");
   property p_fsm;
      go && req_i.addr == 12'h802 && !req_i.wdata[7] && req_i.wdata[3] |=> fsm_rst_o && !unit_rst_o;
   endproperty
   a_fsm: assert property (p_fsm) else $error("fsm reset wrong");
   property p_stat;
      rs |=> rdata_o[6:0] == 7'h60;
   endproperty
   a_stat: assert property (p_stat) else $error("status bits wrong");
   property p_sticky;
      ce_i && sync_error_i ##1 rs |=> rdata_o[7];
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault not seen");
   property p_seed;
      go && req_i.addr == 12'h80a |=> link_cfg_o.scr_seed[14:7] == $past(req_i.wdata);
   endproperty
   a_seed: assert property (p_seed) else $error("seed high wrong");
   property p_rev;
      go && req_i.addr == 12'h805 |=> {link_cfg_o.sync_active_high, link_cfg_o.rev_scrambler,
         link_cfg_o.rev_encoder, link_cfg_o.rev_serial} == {$past(req_i.wdata[5]), $past(req_i.wdata[2:0])};
   endproperty
   a_rev: assert property (p_rev) else $error("control bits wrong");
   property p_prbs;
      go && req_i.addr == 12'h80b |=> link_cfg_o.sequence_type_select == $past(req_i.wdata[1:0]);
   endproperty
   a_prbs: assert property (p_prbs) else $error("sequence_type_select wrong");
   c_rst: cover property (go && req_i.addr == 12'h802);
   c_irq: cover property (irq_o);
   c_pol: cover property (sync_asserted_o && link_cfg_o.sync_active_high);
endmodule

// >>> rx_sync_model.sv
// Purpose: Receiver side that drives the sync request and error lines
// Assumes: Bench tells it when to request sync or flag an error
// Notes: Registered, so the lines settle one cycle after a command
`timescale 1ns/100ps
module rx_sync_model (
   input wire logic clk_i,
   input wire logic act_high_i,
   input wire logic want_i,
   input wire logic err_i,
   output logic sync_req_o = 1'b1,
   output logic sync_error_o = 1'b0
);
   // Drive the request in the sense the control bit selects
   always_ff @(posedge clk_i) begin
      sync_req_o <= act_high_i ? want_i : !want_i;
      sync_error_o <= err_i;
   end
endmodule
